// ---- pkg/tci_pkg.sv ----
`default_nettype none
package tci_pkg;
  localparam int COUNT_W = 16;
  localparam int INTERVAL_W = 12;
  localparam int IDX_W = 6;
  localparam logic [IDX_W-1:0] IDX_CAPTURE_A_RISE_TIME = 6'h22;
  localparam logic [IDX_W-1:0] IDX_CAPTURE_B_RISE_TIME = 6'h23;
  localparam logic [IDX_W-1:0] IDX_CAPTURE_A_FALL_TIME = 6'h24;
  localparam logic [IDX_W-1:0] IDX_CAPTURE_B_FALL_TIME = 6'h25;
  localparam logic [IDX_W-1:0] IDX_INTERVAL_COUNT_LOW = 6'h26;
  localparam logic [IDX_W-1:0] IDX_INTERVAL_COUNT_HIGH = 6'h27;
  localparam logic [IDX_W-1:0] IDX_INTERVAL_RELOAD_LOW = 6'h28;
  localparam logic [IDX_W-1:0] IDX_INTERVAL_RELOAD_HIGH = 6'h29;
  localparam logic [IDX_W-1:0] IDX_CAPTURE_CONFIG = 6'h2A;
  localparam logic [IDX_W-1:0] IDX_CAPTURE_IRQ_ENABLE = 6'h2B;
  localparam logic [IDX_W-1:0] IDX_CAPTURE_IRQ_STATUS = 6'h2C;
  localparam logic [IDX_W-1:0] IDX_INTERVAL_EVENT_STATUS = 6'h2D;
  localparam logic [IDX_W-1:0] IDX_INTERVAL_EVENT_MASK = 6'h2E;
  // capture slots, same order as status and enable bits
  localparam int SLOT_A_RISE = 0;
  localparam int SLOT_A_FALL = 1;
  localparam int SLOT_B_RISE = 2;
  localparam int SLOT_B_FALL = 3;
  localparam int CFG_HOLD_BIT = 7;
  localparam int CFG_PRESCALE_LSB = 4;
  localparam int CFG_WIDE_BIT = 3;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hF8;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [COUNT_W-1:0] RST_COUNT = 16'h0000;
  localparam logic [INTERVAL_W-1:0] RST_INTERVAL = 12'h000;
endpackage
`default_nettype wire

// ---- logic/tci_capture_interval.sv ----
// Functional notes
// - B fall holds prescaled slice, 8-bit mode
// - wide mode: B fall gets upper byte
// - count low read latches upper nibble
// - count high reads latched nibble, top zero
// - two channels, rise and fall registers
// - wide mode: B registers give high byte
// - edges, not loads, raise interrupts; wide-mode B loads raise none
// - hold off: every edge overwrites register
// - hold on: keep first edge until read
// - prescale field selects counter bits n+7:n, 8-bit mode
// - wide enable disables B's own capture
// - enable register gates four capture interrupts
// - status bit set on its edge
// - status cleared only by writing one
// - free-running counter advanced by time clock
// - A rise holds counter at rising edge
`timescale 1ns/1ns
`default_nettype none
module tci_capture_interval
  import tci_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic capture_input_a_i,
  input wire logic capture_input_b_i,
  input wire logic capture_time_clock_i,
  output logic irq_o
);
  function automatic logic [7:0] tci_slice(input logic [COUNT_W-1:0] c, input logic [2:0] n);
    tci_slice = 8'(c >> n);
  endfunction

  logic a_s1, a_s2, a_s3, b_s1, b_s2, b_s3, t_s1, t_s2, t_s3;
  logic tick;
  logic [3:0] edge_ev, src_ev, load, rd_hit, wr_hit;
  logic [COUNT_W-1:0] free_count;
  logic [7:0] cap_time [4];
  logic [7:0] cap_val [4];
  logic [3:0] held;
  logic [7:0] capture_config, capture_irq_enable;
  logic [3:0] capture_irq_status;
  logic [INTERVAL_W-1:0] interval_count, interval_reload;
  logic [7:0] reload_low_stage;
  logic [3:0] count_high_hold;
  logic interval_event_status, interval_event_mask;
  logic acc, wr, rd;
  logic [IDX_W-1:0] idx;
  logic [7:0] next_dat;
  logic hold, wide;
  logic [2:0] prescale;

  // inputs come from pins and another clock: two flops before use
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      {a_s1, a_s2, a_s3} <= 3'h0;
      {b_s1, b_s2, b_s3} <= 3'h0;
      {t_s1, t_s2, t_s3} <= 3'h0;
    end
    else
    begin
      a_s1 <= capture_input_a_i;
      a_s2 <= a_s1;
      a_s3 <= a_s2;
      b_s1 <= capture_input_b_i;
      b_s2 <= b_s1;
      b_s3 <= b_s2;
      t_s1 <= capture_time_clock_i;
      t_s2 <= t_s1;
      t_s3 <= t_s2;
    end
  end

  // only time clock rising edges count as ticks; it must be under half of clk_i
  assign tick = t_s2 & ~t_s3;
  assign hold = capture_config[CFG_HOLD_BIT];
  assign wide = capture_config[CFG_WIDE_BIT];
  assign prescale = capture_config[CFG_PRESCALE_LSB +: 3];

  assign edge_ev[SLOT_A_RISE] = a_s2 & ~a_s3;
  assign edge_ev[SLOT_A_FALL] = ~a_s2 & a_s3;
  assign edge_ev[SLOT_B_RISE] = ~wide & b_s2 & ~b_s3;
  assign edge_ev[SLOT_B_FALL] = ~wide & ~b_s2 & b_s3;
  // in wide mode the B slots follow channel A edges
  assign src_ev[SLOT_A_RISE] = edge_ev[SLOT_A_RISE];
  assign src_ev[SLOT_A_FALL] = edge_ev[SLOT_A_FALL];
  assign src_ev[SLOT_B_RISE] = wide ? edge_ev[SLOT_A_RISE] : edge_ev[SLOT_B_RISE];
  assign src_ev[SLOT_B_FALL] = wide ? edge_ev[SLOT_A_FALL] : edge_ev[SLOT_B_FALL];

  always_comb
  begin
    cap_val[SLOT_A_RISE] = wide ? free_count[7:0] : tci_slice(free_count, prescale);
    cap_val[SLOT_A_FALL] = wide ? free_count[7:0] : tci_slice(free_count, prescale);
    cap_val[SLOT_B_RISE] = wide ? free_count[15:8] : tci_slice(free_count, prescale);
    cap_val[SLOT_B_FALL] = wide ? free_count[15:8] : tci_slice(free_count, prescale);
  end

  assign load = src_ev & ~({4{hold}} & held);

  // wishbone classic: one wait state, ack for one cycle
  assign acc = cyc_i & stb_i & ~ack_o;
  assign wr = acc & we_i & sel_i[0];
  assign rd = acc & ~we_i;
  assign idx = adr_i[7:2];

  always_comb
  begin
    rd_hit[SLOT_A_RISE] = rd & (idx == IDX_CAPTURE_A_RISE_TIME);
    rd_hit[SLOT_A_FALL] = rd & (idx == IDX_CAPTURE_A_FALL_TIME);
    rd_hit[SLOT_B_RISE] = rd & (idx == IDX_CAPTURE_B_RISE_TIME);
    rd_hit[SLOT_B_FALL] = rd & (idx == IDX_CAPTURE_B_FALL_TIME);
    wr_hit[SLOT_A_RISE] = wr & (idx == IDX_CAPTURE_A_RISE_TIME);
    wr_hit[SLOT_A_FALL] = wr & (idx == IDX_CAPTURE_A_FALL_TIME);
    wr_hit[SLOT_B_RISE] = wr & (idx == IDX_CAPTURE_B_RISE_TIME);
    wr_hit[SLOT_B_FALL] = wr & (idx == IDX_CAPTURE_B_FALL_TIME);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      free_count <= RST_COUNT;
    else if (tick)
      free_count <= COUNT_W'(free_count + 16'h0001);
  end

  // software write wins over a capture in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      for (int i = 0; i < 4; i++)
        cap_time[i] <= RST_BYTE;
    else
      for (int i = 0; i < 4; i++)
        if (wr_hit[i])
          cap_time[i] <= dat_i[7:0];
        else if (load[i])
          cap_time[i] <= cap_val[i];
  end

  // a load and a read together leave the slot held
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      held <= 4'h0;
    else
      held <= (held & ~rd_hit) | (load & {4{hold}});
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      capture_irq_status <= RST_NIBBLE;
    else if (wr && idx == IDX_CAPTURE_IRQ_STATUS)
      capture_irq_status <= (capture_irq_status & ~dat_i[3:0]) | edge_ev;
    else
      capture_irq_status <= capture_irq_status | edge_ev;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      capture_config <= RST_BYTE;
      capture_irq_enable <= RST_BYTE;
      interval_event_mask <= 1'b0;
    end
    else if (wr)
    begin
      if (idx == IDX_CAPTURE_CONFIG)
        capture_config <= dat_i[7:0] & CFG_WRITE_MASK;
      if (idx == IDX_CAPTURE_IRQ_ENABLE)
        capture_irq_enable <= {4'h0, dat_i[3:0]};
      if (idx == IDX_INTERVAL_EVENT_MASK)
        interval_event_mask <= dat_i[0];
    end
  end

  // reload takes effect only when the high nibble is written
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      reload_low_stage <= RST_BYTE;
      interval_reload <= RST_INTERVAL;
    end
    else if (wr && idx == IDX_INTERVAL_RELOAD_LOW)
      reload_low_stage <= dat_i[7:0];
    else if (wr && idx == IDX_INTERVAL_RELOAD_HIGH)
      interval_reload <= {dat_i[3:0], reload_low_stage};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      interval_count <= RST_INTERVAL;
    else if (tick)
    begin
      if (interval_count == RST_INTERVAL)
        interval_count <= interval_reload;
      else
        interval_count <= INTERVAL_W'(interval_count - 12'h001);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      interval_event_status <= 1'b0;
    else if (tick && interval_count == RST_INTERVAL)
      interval_event_status <= 1'b1;
    else if (rd && idx == IDX_INTERVAL_EVENT_STATUS)
      interval_event_status <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_high_hold <= RST_NIBBLE;
    else if (rd && idx == IDX_INTERVAL_COUNT_LOW)
      count_high_hold <= interval_count[11:8];
  end

  always_comb
  begin
    next_dat = RST_BYTE;
    unique case (idx)
      IDX_CAPTURE_A_RISE_TIME: next_dat = cap_time[SLOT_A_RISE];
      IDX_CAPTURE_A_FALL_TIME: next_dat = cap_time[SLOT_A_FALL];
      IDX_CAPTURE_B_RISE_TIME: next_dat = cap_time[SLOT_B_RISE];
      IDX_CAPTURE_B_FALL_TIME: next_dat = cap_time[SLOT_B_FALL];
      IDX_INTERVAL_COUNT_LOW: next_dat = interval_count[7:0];
      IDX_INTERVAL_COUNT_HIGH: next_dat = {4'h0, count_high_hold};
      IDX_INTERVAL_RELOAD_LOW: next_dat = reload_low_stage;
      IDX_INTERVAL_RELOAD_HIGH: next_dat = {4'h0, interval_reload[11:8]};
      IDX_CAPTURE_CONFIG: next_dat = capture_config;
      IDX_CAPTURE_IRQ_ENABLE: next_dat = capture_irq_enable;
      IDX_CAPTURE_IRQ_STATUS: next_dat = {4'h0, capture_irq_status};
      IDX_INTERVAL_EVENT_STATUS: next_dat = {7'h00, interval_event_status};
      IDX_INTERVAL_EVENT_MASK: next_dat = {7'h00, interval_event_mask};
      default: next_dat = RST_BYTE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_o <= acc;
      dat_o <= rd ? {24'h000000, next_dat} : 32'h00000000;
    end
  end

  // level output; status stays up until cleared, so no event is lost
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= (|(capture_irq_status & capture_irq_enable[3:0])) |
               (interval_event_status & interval_event_mask);
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_pulse;
    acc |=> ack_o ##1 !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a one-cycle answer");

  property p_counter_step;
    tick |=> free_count == COUNT_W'($past(free_count) + 16'h0001);
  endproperty
  a_counter_step: assert property (p_counter_step) else $error("counter did not step");

  property p_a_rise_latest;
    (edge_ev[SLOT_A_RISE] && !hold && !wr_hit[SLOT_A_RISE]) |=>
      cap_time[SLOT_A_RISE] == $past(cap_val[SLOT_A_RISE]);
  endproperty
  a_a_rise_latest: assert property (p_a_rise_latest) else $error("A rise not overwritten");

  property p_b_fall_slice;
    (!wide && load[SLOT_B_FALL] && !wr_hit[SLOT_B_FALL]) |=>
      cap_time[SLOT_B_FALL] == tci_slice($past(free_count), $past(prescale));
  endproperty
  a_b_fall_slice: assert property (p_b_fall_slice) else $error("B fall slice wrong");

  property p_b_fall_wide;
    (wide && load[SLOT_B_FALL] && !wr_hit[SLOT_B_FALL]) |=>
      cap_time[SLOT_B_FALL] == $past(free_count[15:8]);
  endproperty
  a_b_fall_wide: assert property (p_b_fall_wide) else $error("B fall upper byte wrong");

  property p_hold_keeps;
    (hold && held[SLOT_A_FALL] && !rd_hit[SLOT_A_FALL] && !wr_hit[SLOT_A_FALL]) |=>
      $stable(cap_time[SLOT_A_FALL]) && held[SLOT_A_FALL];
  endproperty
  a_hold_keeps: assert property (p_hold_keeps) else $error("held capture changed");

  property p_wide_blocks_b;
    wide |-> !edge_ev[SLOT_B_RISE] && !edge_ev[SLOT_B_FALL];
  endproperty
  a_wide_blocks_b: assert property (p_wide_blocks_b) else $error("B captured in wide mode");

  property p_status_clear;
    $fell(capture_irq_status[SLOT_A_RISE]) |->
      $past(wr && idx == IDX_CAPTURE_IRQ_STATUS && dat_i[0]);
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status cleared wrongly");

  property p_status_set;
    edge_ev[SLOT_B_FALL] |=> capture_irq_status[SLOT_B_FALL];
  endproperty
  a_status_set: assert property (p_status_set) else $error("status not set on edge");

  property p_irq_follows;
    (|(capture_irq_status & capture_irq_enable[3:0])) |=> irq_o;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("enabled status gave no irq");

  property p_nibble_latch;
    (rd && idx == IDX_INTERVAL_COUNT_LOW) |=> count_high_hold == $past(interval_count[11:8]);
  endproperty
  a_nibble_latch: assert property (p_nibble_latch) else $error("nibble not latched");

  property p_high_read;
    $past(rd && idx == IDX_INTERVAL_COUNT_HIGH) |-> dat_o == {28'h0000000, count_high_hold};
  endproperty
  a_high_read: assert property (p_high_read) else $error("count high read wrong");

  property p_reload;
    (tick && interval_count == RST_INTERVAL) |=>
      interval_count == $past(interval_reload) && interval_event_status;
  endproperty
  a_reload: assert property (p_reload) else $error("interval did not reload");

  property p_irq_gated;
    (!(|(capture_irq_status & capture_irq_enable[3:0])) &&
      !(interval_event_status && interval_event_mask)) |=> !irq_o;
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("masked status gave irq");

  property p_held_clear;
    (rd_hit[SLOT_A_RISE] && !load[SLOT_A_RISE]) |=> !held[SLOT_A_RISE];
  endproperty
  a_held_clear: assert property (p_held_clear) else $error("read did not rearm");

  property p_b_rise_wide;
    (wide && load[SLOT_B_RISE] && !wr_hit[SLOT_B_RISE]) |=>
      cap_time[SLOT_B_RISE] == $past(free_count[15:8]);
  endproperty
  a_b_rise_wide: assert property (p_b_rise_wide) else $error("B rise upper byte wrong");

  property p_wide_b_stable;
    (wide && !edge_ev[SLOT_A_RISE] && !wr_hit[SLOT_B_RISE]) |=>
      $stable(cap_time[SLOT_B_RISE]);
  endproperty
  a_wide_b_stable: assert property (p_wide_b_stable) else $error("B rise moved in wide mode");

  c_wide_capture: cover property (wide && load[SLOT_B_RISE]);
  c_hold_ignore: cover property (hold && held[SLOT_A_RISE] && edge_ev[SLOT_A_RISE]);
  c_status_w1c: cover property (wr && idx == IDX_CAPTURE_IRQ_STATUS && |capture_irq_status);
  c_interval_event: cover property (tick && interval_count == RST_INTERVAL && irq_o);
endmodule
`default_nettype wire

// ---- verification/tci_edge_source.sv ----
`timescale 1ns/1ns
`default_nettype none
module tci_edge_source
(
  input wire logic clk_i,
  output logic capture_input_a_o,
  output logic capture_input_b_o,
  output logic capture_time_clock_o
);
  // time clock stands still between ticks so the count stays known
  initial
  begin
    capture_input_a_o = 1'b0;
    capture_input_b_o = 1'b0;
    capture_time_clock_o = 1'b0;
  end
  // at least four clk per phase, well above the two-flop sync limit
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      capture_time_clock_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      capture_time_clock_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask
  task automatic pin(input logic b, input logic v);
    @(posedge clk_i);
    if (b)
      capture_input_b_o <= v;
    else
      capture_input_a_o <= v;
    repeat (6) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ---- verification/timer_capture_interval_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module timer_capture_interval_bench;
  import tci_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic ack_o, irq_o;
  wire logic a_pin, b_pin, t_clk;
  int failures = 0;
  int checks_done = 0;
  logic [15:0] cnt;
  logic [7:0] v;
  logic [3:0] sel_use = 4'h1;
  logic [1:0] adr_lo = 2'h0;
  logic [23:0] dat_hi = 24'h000000;

  tci_capture_interval uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .capture_input_a_i(a_pin), .capture_input_b_i(b_pin), .capture_time_clock_i(t_clk),
    .irq_o(irq_o));
  tci_edge_source pm (.clk_i(clk_i), .capture_input_a_o(a_pin), .capture_input_b_o(b_pin),
    .capture_time_clock_o(t_clk));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one classic cycle; read data taken at the ack edge
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= sel_use;
    adr_i <= {idx, adr_lo};
    dat_i <= {dat_hi, d};
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    v = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (k >= 50)
    begin
      failures++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rd(input string what, input logic [5:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(what, v, exp);
  endtask
  // irq is registered: let it settle before looking
  task automatic irq_is(input logic [7:0] exp);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk("irq", {7'h00, irq_o}, exp);
  endtask

  initial
  begin
    repeat (60000) @(posedge clk_i);
    failures++;
    end_of_test();
  end

  initial
  begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'h1;
    dat_i = 32'h00000000;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 34; i < 45; i++)
      rd("reset", i[5:0], 8'h00);
    rd("unmapped", 6'h30, 8'h00);
    wr(IDX_INTERVAL_COUNT_LOW, 8'h5A);
    rd("ro count", IDX_INTERVAL_COUNT_LOW, 8'h00);
    wr(IDX_CAPTURE_CONFIG, 8'hFF);
    rd("config", IDX_CAPTURE_CONFIG, 8'hF8);
    pm.tick(421);
    cnt = 16'h01A5;
    for (int n = 0; n < 8; n++)
    begin
      wr(IDX_CAPTURE_CONFIG, {1'b0, n[2:0], 4'h0});
      pm.pin(1'b0, 1'b1);
      pm.pin(1'b1, 1'b1);
      pm.pin(1'b0, 1'b0);
      pm.pin(1'b1, 1'b0);
      v = 8'(cnt >> n);
      rd("a rise", IDX_CAPTURE_A_RISE_TIME, 8'(cnt >> n));
      rd("b rise", IDX_CAPTURE_B_RISE_TIME, 8'(cnt >> n));
      rd("a fall", IDX_CAPTURE_A_FALL_TIME, 8'(cnt >> n));
      rd("b fall", IDX_CAPTURE_B_FALL_TIME, 8'(cnt >> n));
    end
    rd("status", IDX_CAPTURE_IRQ_STATUS, 8'h0F);
    wr(IDX_CAPTURE_IRQ_STATUS, 8'h01);
    rd("w1c", IDX_CAPTURE_IRQ_STATUS, 8'h0E);
    wr(IDX_CAPTURE_IRQ_STATUS, 8'h0E);
    wr(IDX_CAPTURE_IRQ_ENABLE, 8'h02);
    pm.pin(1'b0, 1'b1);
    irq_is(8'h00);
    pm.pin(1'b0, 1'b0);
    irq_is(8'h01);
    wr(IDX_CAPTURE_IRQ_STATUS, 8'h03);
    irq_is(8'h00);
    wr(IDX_CAPTURE_IRQ_ENABLE, 8'h00);
    wr(IDX_CAPTURE_CONFIG, 8'h80);
    pm.tick(1);
    cnt = 16'h01A6;
    pm.pin(1'b0, 1'b1);
    pm.tick(1);
    pm.pin(1'b0, 1'b0);
    pm.pin(1'b0, 1'b1);
    rd("held", IDX_CAPTURE_A_RISE_TIME, 8'hA6);
    pm.tick(1);
    pm.pin(1'b0, 1'b0);
    pm.pin(1'b0, 1'b1);
    rd("rearmed", IDX_CAPTURE_A_RISE_TIME, 8'hA8);
    wr(IDX_CAPTURE_IRQ_STATUS, 8'h0F);
    wr(IDX_CAPTURE_CONFIG, 8'h08);
    pm.tick(3);
    pm.pin(1'b0, 1'b0);
    pm.pin(1'b1, 1'b1);
    rd("wide b fall", IDX_CAPTURE_B_FALL_TIME, 8'h01);
    rd("wide a fall", IDX_CAPTURE_A_FALL_TIME, 8'hAB);
    rd("b ignored", IDX_CAPTURE_IRQ_STATUS, 8'h02);
    pm.pin(1'b0, 1'b1);
    rd("wide b rise", IDX_CAPTURE_B_RISE_TIME, 8'h01);
    rd("wide a rise", IDX_CAPTURE_A_RISE_TIME, 8'hAB);
    wr(IDX_INTERVAL_RELOAD_LOW, 8'h03);
    wr(IDX_INTERVAL_RELOAD_HIGH, 8'h02);
    rd("event", IDX_INTERVAL_EVENT_STATUS, 8'h01);
    rd("event read", IDX_INTERVAL_EVENT_STATUS, 8'h00);
    pm.tick(2);
    rd("count low", IDX_INTERVAL_COUNT_LOW, 8'h02);
    pm.tick(3);
    rd("latched", IDX_INTERVAL_COUNT_HIGH, 8'h02);
    rd("count low", IDX_INTERVAL_COUNT_LOW, 8'hFF);
    rd("count high", IDX_INTERVAL_COUNT_HIGH, 8'h01);
    rd("reload high", IDX_INTERVAL_RELOAD_HIGH, 8'h02);
    // lane 0 off: the write must be dropped
    sel_use = 4'h0;
    wr(IDX_INTERVAL_EVENT_MASK, 8'h01);
    irq_is(8'h00);
    sel_use = 4'hF;
    adr_lo = 2'h3;
    dat_hi = 24'hFFFFFF;
    wr(IDX_INTERVAL_EVENT_MASK, 8'h01);
    irq_is(8'h01);
    rd("mask", IDX_INTERVAL_EVENT_MASK, 8'h01);
    rd("event again", IDX_INTERVAL_EVENT_STATUS, 8'h01);
    irq_is(8'h00);
    // pins back to idle low, else release of reset shows a false edge
    pm.pin(1'b0, 1'b0);
    pm.pin(1'b1, 1'b0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("reset config", IDX_CAPTURE_CONFIG, 8'h00);
    rd("reset status", IDX_CAPTURE_IRQ_STATUS, 8'h00);
    rd("reset mask", IDX_INTERVAL_EVENT_MASK, 8'h00);
    rd("reset reload", IDX_INTERVAL_RELOAD_HIGH, 8'h00);
    irq_is(8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
